// >>> hw/pmhs_pkg.sv
// Operation
// - standby: stop core, pixel clocks; memory, PLLs run
// - suspend: PLLs off, memory clocked from oscillator
// - sleep: every clock and PLL stopped
// - select mode, then set go bit to enter
// - clear go bit to return to normal
// - status inhibit bit confirms entry and exit
// - sleep: memory power-down or self-refresh first
// - serial host keeps oscillator running in sleep
// - host re-enables stopped oscillator on sleep exit
// - host programs refresh setting before suspend
// - no panel drive in power saving
// - pll ready flag set once clocks switched
// - command/data select decodes the four cycles
// - register read: command write, then data read
// - status bit 7 shows write FIFO full
// - status bit 6 shows write FIFO empty
// - status bits 5/4 show read FIFO full/empty
// - status bit 3 shows engine busy
// - status bit 2 shows display memory ready
// - inhibit rises on internal busy or after PLL clocks stopped
// - status bit 0 mirrors interrupt output
// - 8-bit registers; status readable only
`default_nettype none
package pmhs_pkg;
	// device register addresses
	localparam logic [7:0] PMHS_ADDR_CCR     = 8'h01;
	localparam logic [7:0] PMHS_ADDR_PWR     = 8'hDF;
	localparam logic [7:0] PMHS_ADDR_MEMCTL  = 8'hE0;
	localparam logic [7:0] PMHS_ADDR_REFRESH = 8'hE1;
	localparam logic [7:0] PMHS_ADDR_MEMINIT = 8'hE4;
	// field positions
	localparam int PMHS_PWR_GO      = 7;
	localparam int PMHS_PWR_OSC     = 6;
	localparam int PMHS_MEM_SELFREF = 7;
	localparam int PMHS_INIT_START  = 0;
	localparam int PMHS_ST_INHIBIT  = 1;
	// reset values
	localparam logic [6:0] PMHS_CCR_RESET = 7'h48;
	localparam logic [7:0] PMHS_REG_RESET = 8'h00;
	// host-side software port
	localparam logic [1:0] PMHS_SW_CTRL    = 2'h0;
	localparam logic [1:0] PMHS_SW_REFRESH = 2'h1;
	localparam logic [1:0] PMHS_SW_DEVSTAT = 2'h2;
	localparam logic [1:0] PMHS_SW_STAT    = 2'h3;
	typedef enum logic [1:0] {
		PMHS_MODE_NORMAL  = 2'b00,
		PMHS_MODE_STANDBY = 2'b01,
		PMHS_MODE_SUSPEND = 2'b10,
		PMHS_MODE_SLEEP   = 2'b11
	} pmhs_mode_t;
	// timing
	localparam int unsigned PMHS_CLK_PERIOD_NS = 20;
	localparam int unsigned PMHS_PLL_LOCK_NS   = 20000;
	localparam int unsigned PMHS_CLK_STOP_NS   = 80;
	function automatic logic [15:0] pmhs_cycles_up(input int unsigned ns);
		return 16'((ns + PMHS_CLK_PERIOD_NS - 1) / PMHS_CLK_PERIOD_NS);
	endfunction
	localparam logic [15:0] PMHS_PLL_LOCK_CYCLES = pmhs_cycles_up(PMHS_PLL_LOCK_NS);
	localparam logic [15:0] PMHS_CLK_STOP_CYCLES = pmhs_cycles_up(PMHS_CLK_STOP_NS);
endpackage
`default_nettype wire

// >>> hw/pmhs_bus_if.sv
`default_nettype none
interface pmhs_bus_if;
	logic       csN;
	logic       cmdDataSel;
	logic       wrStb;
	logic       rdStb;
	logic [7:0] wrData;
	logic [7:0] rdData;
	modport device (
		input  csN,
		input  cmdDataSel,
		input  wrStb,
		input  rdStb,
		input  wrData,
		output rdData
	);
	modport host (
		output csN,
		output cmdDataSel,
		output wrStb,
		output rdStb,
		output wrData,
		input  rdData
	);
endinterface
`default_nettype wire

// >>> hw/pmhs_device.sv
`default_nettype none
module pmhs_device #(
	parameter logic [15:0] LOCK_CYCLES = pmhs_pkg::PMHS_PLL_LOCK_CYCLES,
	parameter logic [15:0] STOP_CYCLES = pmhs_pkg::PMHS_CLK_STOP_CYCLES
) (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	input  wire logic       clkEn,
	// host register port
	pmhs_bus_if.device      bus,
	// core state
	input  wire logic       wrFifoFull,
	input  wire logic       wrFifoEmpty,
	input  wire logic       rdFifoFull,
	input  wire logic       rdFifoEmpty,
	input  wire logic       engineBusy,
	input  wire logic       memInitDone,
	input  wire logic       intActive,
	input  wire logic       internalBusy,
	input  wire logic       hostSerial,
	// clock and power control
	output logic            coreClkEn,
	output logic            pixelClkEn,
	output logic            memClkEn,
	output logic            memClkFromOsc,
	output logic            corePllOn,
	output logic            memPllOn,
	output logic            pixelPllOn,
	output logic            oscEn,
	output logic            memPowerDown,
	output logic            memSelfRefresh,
	output logic            panelDriveEn,
	output logic            dramInitStart,
	output logic [7:0]      memRefreshDiv
);
	import pmhs_pkg::*;

	typedef enum logic [2:0] {
		PMHS_ST_POWERUP = 3'b000,
		PMHS_ST_NORMAL  = 3'b001,
		PMHS_ST_ENTER   = 3'b010,
		PMHS_ST_SAVING  = 3'b011,
		PMHS_ST_WAKE    = 3'b100
	} pmhs_state_t;

	pmhs_state_t state;
	pmhs_state_t next_state;
	pmhs_mode_t  activeMode;
	pmhs_mode_t  next_activeMode;
	logic [15:0] cnt;
	logic [15:0] next_cnt;
	logic        pllReady;
	logic        next_pllReady;
	logic [7:0]  regAddr;
	logic [7:0]  pwrCtrl;
	logic [7:0]  memCtrl;
	logic [7:0]  refreshDiv;
	logic [7:0]  memInit;
	logic [6:0]  ccrCfg;

	// host cycle decode
	wire cmdWrite   = !bus.csN && bus.wrStb && !bus.cmdDataSel;
	wire dataWrite  = !bus.csN && bus.wrStb && bus.cmdDataSel;
	wire statusRead = !bus.csN && bus.rdStb && !bus.cmdDataSel;
	wire dataRead   = !bus.csN && bus.rdStb && bus.cmdDataSel;

	wire pmhs_mode_t selMode = pmhs_mode_t'(pwrCtrl[1:0]);
	wire enterReq = pwrCtrl[PMHS_PWR_GO] && selMode != PMHS_MODE_NORMAL;
	wire exitReq  = !pwrCtrl[PMHS_PWR_GO];
	wire cntDone  = cnt == 16'h0000;
	wire saving   = state == PMHS_ST_SAVING;
	wire gated    = state == PMHS_ST_ENTER || saving || state == PMHS_ST_WAKE;

	// inhibit from internal busy, or once PLL clocks are stopped, held until relocked
	wire inhibit  = internalBusy || saving || state == PMHS_ST_WAKE;
	wire memReady = memInit[PMHS_INIT_START] && memInitDone;
	wire [7:0] hostStatus = {
		wrFifoFull,
		wrFifoEmpty,
		rdFifoFull,
		rdFifoEmpty,
		engineBusy,
		memReady,
		inhibit,
		intActive
	};

	// readable registers, status not among them
	wire [7:0] regData =
		(regAddr == PMHS_ADDR_CCR)     ? {pllReady, ccrCfg} :
		(regAddr == PMHS_ADDR_PWR)     ? pwrCtrl :
		(regAddr == PMHS_ADDR_MEMCTL)  ? memCtrl :
		(regAddr == PMHS_ADDR_REFRESH) ? refreshDiv :
		(regAddr == PMHS_ADDR_MEMINIT) ? memInit : 8'h00;

	// register writes
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			regAddr    <= PMHS_REG_RESET;
			pwrCtrl    <= PMHS_REG_RESET;
			memCtrl    <= PMHS_REG_RESET;
			refreshDiv <= PMHS_REG_RESET;
			memInit    <= PMHS_REG_RESET;
			ccrCfg     <= PMHS_CCR_RESET;
		end
		else if (clkEn)
		begin
			if (cmdWrite)
				regAddr <= bus.wrData;
			if (dataWrite && regAddr == PMHS_ADDR_PWR)
				pwrCtrl <= bus.wrData;
			if (dataWrite && regAddr == PMHS_ADDR_MEMCTL)
				memCtrl <= bus.wrData;
			if (dataWrite && regAddr == PMHS_ADDR_REFRESH)
				refreshDiv <= bus.wrData;
			if (dataWrite && regAddr == PMHS_ADDR_MEMINIT)
				memInit <= bus.wrData;
			if (dataWrite && regAddr == PMHS_ADDR_CCR)
				ccrCfg <= bus.wrData[6:0];
		end
	end

	// read data stands one cycle after the strobe
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			bus.rdData <= 8'h00;
		else if (clkEn)
			bus.rdData <= statusRead ? hostStatus : (dataRead ? regData : 8'h00);
	end

	// power sequencer
	always_comb
	begin
		next_state      = state;
		next_activeMode = activeMode;
		next_cnt        = cntDone ? cnt : cnt - 16'h0001;
		next_pllReady   = pllReady;
		unique case (state)
			PMHS_ST_POWERUP:
				if (cntDone)
				begin
					next_state    = PMHS_ST_NORMAL;
					next_pllReady = 1'b1;
				end
			PMHS_ST_NORMAL:
				if (enterReq)
				begin
					next_state      = PMHS_ST_ENTER;
					next_activeMode = selMode;
					next_cnt        = STOP_CYCLES;
					next_pllReady   = 1'b0;
				end
			PMHS_ST_ENTER:
				if (cntDone)
					next_state = PMHS_ST_SAVING;
			PMHS_ST_SAVING:
				if (exitReq)
				begin
					next_state = PMHS_ST_WAKE;
					next_cnt   = LOCK_CYCLES;
				end
			PMHS_ST_WAKE:
				if (cntDone)
				begin
					next_state      = PMHS_ST_NORMAL;
					next_activeMode = PMHS_MODE_NORMAL;
					next_pllReady   = 1'b1;
				end
			default:
			begin
				next_state = PMHS_ST_POWERUP;
				next_cnt   = LOCK_CYCLES;
			end
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			state      <= PMHS_ST_POWERUP;
			activeMode <= PMHS_MODE_NORMAL;
			cnt        <= LOCK_CYCLES;
			pllReady   <= 1'b0;
		end
		else if (clkEn)
		begin
			state      <= next_state;
			activeMode <= next_activeMode;
			cnt        <= next_cnt;
			pllReady   <= next_pllReady;
		end
	end

	// clock, PLL and memory controls
	wire standby  = activeMode == PMHS_MODE_STANDBY;
	wire sleep    = activeMode == PMHS_MODE_SLEEP;
	wire oscMem   = activeMode == PMHS_MODE_SUSPEND && (saving || state == PMHS_ST_WAKE);
	wire pllsDown = saving && !standby;
	wire sleepOsc = saving && sleep && !hostSerial && !pwrCtrl[PMHS_PWR_OSC];

	assign coreClkEn      = !gated;
	assign pixelClkEn     = !gated;
	assign memClkEn       = !gated || standby || oscMem;
	assign memClkFromOsc  = oscMem;
	assign corePllOn      = !pllsDown;
	assign memPllOn       = !pllsDown;
	assign pixelPllOn     = !pllsDown;
	assign oscEn          = !sleepOsc;
	assign memPowerDown   = gated && sleep && !memCtrl[PMHS_MEM_SELFREF];
	assign memSelfRefresh = gated && sleep && memCtrl[PMHS_MEM_SELFREF];
	assign panelDriveEn   = !gated;
	assign dramInitStart  = memInit[PMHS_INIT_START];
	assign memRefreshDiv  = refreshDiv;
endmodule // pmhs_device
`default_nettype wire

// >>> hw/pmhs_host.sv
`default_nettype none
module pmhs_host (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	input  wire logic       clkEn,
	// device register port
	pmhs_bus_if.host        bus,
	// software port
	input  wire logic [1:0] swAddr,
	input  wire logic [7:0] swWrData,
	input  wire logic       swWr,
	input  wire logic       swRd,
	output logic [7:0]      swRdData,
	// panel
	output logic            panelPowerOff
);
	import pmhs_pkg::*;

	typedef enum logic [3:0] {
		PMHS_H_IDLE    = 4'h0,
		PMHS_H_REF_CMD = 4'h1,
		PMHS_H_REF_DAT = 4'h2,
		PMHS_H_PWR_CMD = 4'h3,
		PMHS_H_SEL_DAT = 4'h4,
		PMHS_H_GO_DAT  = 4'h5,
		PMHS_H_POLL    = 4'h6,
		PMHS_H_WAIT    = 4'h7,
		PMHS_H_CHECK   = 4'h8
	} pmhs_hstate_t;

	pmhs_hstate_t hState;
	logic [7:0]   hostCtrl;
	logic [7:0]   refreshVal;
	logic [7:0]   devStatus;
	logic         busy;

	wire pmhs_mode_t reqMode = pmhs_mode_t'(hostCtrl[1:0]);
	wire enter   = hostCtrl[PMHS_PWR_GO];
	wire expect1 = enter && reqMode != PMHS_MODE_NORMAL;
	wire start   = swWr && swAddr == PMHS_SW_CTRL && !busy;
	wire [7:0] goData = enter ? {1'b1, 5'h00, reqMode} : {2'b01, 4'h0, reqMode};
	wire [7:0] swRegData =
		(swAddr == PMHS_SW_CTRL)    ? hostCtrl :
		(swAddr == PMHS_SW_REFRESH) ? refreshVal :
		(swAddr == PMHS_SW_DEVSTAT) ? devStatus : {6'h00, panelPowerOff, busy};

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			hostCtrl   <= PMHS_REG_RESET;
			refreshVal <= PMHS_REG_RESET;
			swRdData   <= 8'h00;
		end
		else if (clkEn)
		begin
			if (start)
				hostCtrl <= swWrData;
			if (swWr && swAddr == PMHS_SW_REFRESH)
				refreshVal <= swWrData;
			swRdData <= swRd ? swRegData : 8'h00;
		end
	end

	// bus cycle issued in the state after the one that sets it
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			hState         <= PMHS_H_IDLE;
			busy           <= 1'b0;
			panelPowerOff  <= 1'b0;
			devStatus      <= 8'h00;
			bus.csN        <= 1'b1;
			bus.cmdDataSel <= 1'b0;
			bus.wrStb      <= 1'b0;
			bus.rdStb      <= 1'b0;
			bus.wrData     <= 8'h00;
		end
		else if (clkEn)
		begin
			bus.csN   <= 1'b1;
			bus.wrStb <= 1'b0;
			bus.rdStb <= 1'b0;
			unique case (hState)
				PMHS_H_IDLE:
					if (start)
					begin
						busy <= 1'b1;
						// panel goes off only ahead of a real power-saving entry
						if (swWrData[PMHS_PWR_GO] && swWrData[1:0] != PMHS_MODE_NORMAL)
							panelPowerOff <= 1'b1;
						hState <= (swWrData[PMHS_PWR_GO] && swWrData[1:0] == PMHS_MODE_SUSPEND)
							? PMHS_H_REF_CMD : PMHS_H_PWR_CMD;
					end
				PMHS_H_REF_CMD:
				begin
					{bus.csN, bus.wrStb, bus.cmdDataSel} <= 3'b010;
					bus.wrData <= PMHS_ADDR_REFRESH;
					hState     <= PMHS_H_REF_DAT;
				end
				PMHS_H_REF_DAT:
				begin
					{bus.csN, bus.wrStb, bus.cmdDataSel} <= 3'b011;
					bus.wrData <= refreshVal;
					hState     <= PMHS_H_PWR_CMD;
				end
				PMHS_H_PWR_CMD:
				begin
					{bus.csN, bus.wrStb, bus.cmdDataSel} <= 3'b010;
					bus.wrData <= PMHS_ADDR_PWR;
					hState     <= enter ? PMHS_H_SEL_DAT : PMHS_H_GO_DAT;
				end
				PMHS_H_SEL_DAT:
				begin
					{bus.csN, bus.wrStb, bus.cmdDataSel} <= 3'b011;
					bus.wrData <= {6'h00, reqMode};
					hState     <= PMHS_H_GO_DAT;
				end
				PMHS_H_GO_DAT:
				begin
					{bus.csN, bus.wrStb, bus.cmdDataSel} <= 3'b011;
					bus.wrData <= goData;
					hState     <= PMHS_H_POLL;
				end
				PMHS_H_POLL:
				begin
					{bus.csN, bus.rdStb, bus.cmdDataSel} <= 3'b010;
					hState <= PMHS_H_WAIT;
				end
				PMHS_H_WAIT:
					hState <= PMHS_H_CHECK;
				PMHS_H_CHECK:
				begin
					devStatus <= bus.rdData;
					if (bus.rdData[PMHS_ST_INHIBIT] == expect1)
					begin
						busy   <= 1'b0;
						hState <= PMHS_H_IDLE;
						if (!enter)
							panelPowerOff <= 1'b0;
					end
					else
						hState <= PMHS_H_POLL;
				end
				default:
					hState <= PMHS_H_IDLE;
			endcase
		end
	end
endmodule // pmhs_host
`default_nettype wire

// >>> dv/pmhs_properties.sv
`default_nettype none
module pmhs_properties (
	// clock and reset
	input wire logic       ref_clk,
	input wire logic       resetn,
	// register port
	input wire logic       csN,
	input wire logic       cmdDataSel,
	input wire logic       wrStb,
	input wire logic       rdStb,
	input wire logic [7:0] wrData,
	input wire logic [7:0] rdData
);
	import pmhs_pkg::*;
	logic [7:0] addr;
	logic [7:0] lastPwr;
	logic       refreshSeen;
	wire        cmdWr  = !csN && wrStb && !cmdDataSel;
	wire        dataWr = !csN && wrStb && cmdDataSel;
	wire        pwrWr  = dataWr && addr == PMHS_ADDR_PWR;
	// latched address, last power control value, refresh seen since last entry
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			addr <= 8'h00;
			lastPwr <= 8'h00;
			refreshSeen <= 1'b0;
		end
		else
		begin
			if (cmdWr)
				addr <= wrData;
			if (pwrWr)
				lastPwr <= wrData;
			if (dataWr && addr == PMHS_ADDR_REFRESH)
				refreshSeen <= 1'b1;
			else if (pwrWr && wrData[7])
				refreshSeen <= 1'b0;
		end
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);
	sequence s_cmd_write;
		cmdWr;
	endsequence
	sequence s_data_write;
		dataWr;
	endsequence
	sequence s_status_read;
		!csN && rdStb && !cmdDataSel;
	endsequence
	a_strobe_selects: assert property ((wrStb || rdStb) |-> !csN)
		else $error("strobe seen with chip select high");
	a_one_strobe: assert property (!csN |-> wrStb != rdStb)
		else $error("selected cycle without exactly one strobe");
	a_rddata_idle: assert property (!$past(rdStb) |-> rdData == 8'h00)
		else $error("read data outside its answer cycle");
	a_cmd_then_data: assert property (s_cmd_write |=> s_data_write)
		else $error("command write not followed by data write");
	a_cmd_addr_known: assert property (s_cmd_write |->
		wrData == PMHS_ADDR_PWR || wrData == PMHS_ADDR_REFRESH)
		else $error("command write to unexpected address");
	a_enter_after_select: assert property ((pwrWr && wrData[PMHS_PWR_GO]) |->
		!lastPwr[PMHS_PWR_GO] && lastPwr[1:0] == wrData[1:0])
		else $error("entry without mode selected first");
	a_refresh_first: assert property ((pwrWr && wrData == 8'h82) |-> refreshSeen)
		else $error("suspend entry without refresh setting");
	a_osc_wake: assert property ((pwrWr && !wrData[PMHS_PWR_GO] &&
		lastPwr[PMHS_PWR_GO] && lastPwr[1:0] == PMHS_MODE_SLEEP) |-> wrData[PMHS_PWR_OSC])
		else $error("sleep exit without oscillator wake");
	a_poll_spacing: assert property (s_status_read |=> !rdStb)
		else $error("status poll answer overrun");
endmodule // pmhs_properties
`default_nettype wire

// >>> dv/test_pmhs.sv
`default_nettype none
module test_pmhs;
	timeunit 1ns;
	timeprecision 1ns;
	import pmhs_pkg::*;
	localparam logic [7:0] EXP_CLK [4] = '{8'hEF, 8'h2F, 8'h31, 8'h00};
	logic       ref_clk;
	logic       resetn;
	logic       hostSerial;
	logic       intBusy;
	logic [6:0] devIn;
	logic [1:0] swAddr;
	logic [7:0] swWrData;
	logic       swWr;
	logic       swRd;
	logic [7:0] swRdData;
	logic       panelPowerOff;
	logic       coreClkEn, pixelClkEn, memClkEn, memClkFromOsc;
	logic       corePllOn, memPllOn, pixelPllOn, oscEn;
	logic       memPowerDown, memSelfRefresh, panelDriveEn;
	logic [7:0] memRefreshDiv;
	int         checks;
	int         n_mismatch;
	wire  [7:0] clkVec = {coreClkEn, pixelClkEn, memClkEn, memClkFromOsc,
		corePllOn, memPllOn, pixelPllOn, oscEn};
	wire  [7:0] pwrVec = {memPowerDown, memSelfRefresh, panelDriveEn, panelPowerOff, 4'h0};
	pmhs_bus_if bus ();
	pmhs_device #(.LOCK_CYCLES(16'h0008), .STOP_CYCLES(16'h0002)) pmhs_device_inst (
		.ref_clk(ref_clk), .resetn(resetn), .clkEn(1'b1), .bus(bus),
		.wrFifoFull(devIn[6]), .wrFifoEmpty(devIn[5]), .rdFifoFull(devIn[4]),
		.rdFifoEmpty(devIn[3]), .engineBusy(devIn[2]), .memInitDone(devIn[1]),
		.intActive(devIn[0]), .internalBusy(intBusy), .hostSerial(hostSerial),
		.coreClkEn(coreClkEn), .pixelClkEn(pixelClkEn), .memClkEn(memClkEn),
		.memClkFromOsc(memClkFromOsc), .corePllOn(corePllOn), .memPllOn(memPllOn),
		.pixelPllOn(pixelPllOn), .oscEn(oscEn), .memPowerDown(memPowerDown),
		.memSelfRefresh(memSelfRefresh), .panelDriveEn(panelDriveEn),
		.dramInitStart(), .memRefreshDiv(memRefreshDiv));
	pmhs_host pmhs_host_inst (
		.ref_clk(ref_clk), .resetn(resetn), .clkEn(1'b1), .bus(bus),
		.swAddr(swAddr), .swWrData(swWrData), .swWr(swWr), .swRd(swRd),
		.swRdData(swRdData), .panelPowerOff(panelPowerOff));
	pmhs_properties pmhs_properties_inst (
		.ref_clk(ref_clk), .resetn(resetn), .csN(bus.csN), .cmdDataSel(bus.cmdDataSel),
		.wrStb(bus.wrStb), .rdStb(bus.rdStb), .wrData(bus.wrData), .rdData(bus.rdData));
	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	task results;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task check(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task sw_write(input logic [1:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		swAddr <= a;
		swWrData <= d;
		swWr <= 1'b1;
		@(posedge ref_clk);
		swWr <= 1'b0;
	endtask
	task sw_read(input logic [1:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		swAddr <= a;
		swRd <= 1'b1;
		@(posedge ref_clk);
		swRd <= 1'b0;
		@(negedge ref_clk);
		d = swRdData;
	endtask
	// poll the host busy flag under a bound
	task wait_idle;
		int n;
		logic [7:0] d;
		n = 0;
		d = 8'h01;
		while (d[0] !== 1'b0 && n < 300)
		begin
			sw_read(2'h3, d);
			n++;
		end
		if (n >= 300)
		begin
			n_mismatch++;
			results;
		end
	endtask
	task t_after_reset;
		logic [7:0] d;
		check(clkVec, 8'hEF);
		check(pwrVec, 8'h20);
		sw_read(2'h3, d);
		check(d, 8'h00);
	endtask
	// mode 00 ignored; internal busy holds inhibit and keeps the host polling
	task t_mode_zero;
		logic [7:0] d;
		@(posedge ref_clk);
		intBusy <= 1'b1;
		sw_write(2'h0, 8'h80);
		repeat (12) @(posedge ref_clk);
		sw_read(2'h3, d);
		check(d, 8'h01);
		sw_read(2'h2, d);
		check(d & 8'h02, 8'h02);
		@(posedge ref_clk);
		intBusy <= 1'b0;
		wait_idle;
		check(clkVec, 8'hEF);
		check(pwrVec, 8'h20);
		sw_read(2'h2, d);
		check(d & 8'h02, 8'h00);
	endtask
	task t_power_mode(input logic [1:0] mode, input logic serial, input logic [6:0] p);
		logic [7:0] d;
		@(posedge ref_clk);
		devIn <= p;
		hostSerial <= serial;
		if (mode == 2'b10)
			sw_write(2'h1, 8'h5A);
		sw_write(2'h0, 8'h80 | {6'h00, mode});
		// refused while the entry runs
		sw_write(2'h0, 8'h80);
		wait_idle;
		check(clkVec, EXP_CLK[mode] | {7'h00, mode == 2'b11 && serial});
		check(pwrVec, mode == 2'b11 ? 8'h90 : 8'h10);
		sw_read(2'h2, d);
		check(d, {p[6:2], 1'b0, 1'b1, p[0]});
		if (mode == 2'b10)
			check(memRefreshDiv, 8'h5A);
		sw_write(2'h0, {6'h00, mode});
		wait_idle;
		check(clkVec, 8'hEF);
		check(pwrVec, 8'h20);
		sw_read(2'h2, d);
		check(d, {p[6:2], 1'b0, 1'b0, p[0]});
	endtask
	initial
	begin
		resetn = 1'b0;
		hostSerial = 1'b0;
		intBusy = 1'b0;
		devIn = 7'h28;
		swAddr = 2'h0;
		swWrData = 8'h00;
		swWr = 1'b0;
		swRd = 1'b0;
		checks = 0;
		n_mismatch = 0;
		repeat (20) @(posedge ref_clk);
		resetn <= 1'b1;
		t_after_reset;
		t_mode_zero;
		t_power_mode(2'b01, 1'b0, 7'h28);
		t_power_mode(2'b10, 1'b0, 7'h55);
		t_power_mode(2'b11, 1'b0, 7'h2A);
		t_power_mode(2'b11, 1'b1, 7'h43);
		results;
	end
endmodule // test_pmhs
`default_nettype wire
